// *** tac_pkg.sv ***
// Constants, carriers and decode helpers for the transmit mode and
// arbitration control block. Assumes a single 100 MHz system clock.
//
// Summary of operation
// - Hold control word; bit0 AMPS, bit1 narrowband
// - Bit2 selects voice channel, else control
// - Bit3 selects FOCC B-word, else A-word
// - Bit4 enables automatic arbitration, failure disables transmit
// - Bit5 enables SAT or DSAT/DST output
// - Bit6 enables ST or DST generation
// - Bit7 timer cycles continuously, else stops
// - All transmit enables clear mutes transmitter
// - Data only, bit2 clear: wideband RECC data
// - Voice+data, bits 2 set: wideband RVC data
// - Voice+data, bit6 set: ST mixed with voice
// - Voice+supervisory, bit5 set: SAT with voice
// - All enables, bits 2,5,6 set: ST+SAT+voice
// - Voice only, bits1,2 set: narrowband data+voice
// - Voice only, bits 1,2,5,6: DST+voice
// - Voice only, bits 1,2,5, not 6: DSAT+voice
// - Software arbitration: flag failure, terminal stays inactive
// - Hardware arbitration: switch amplifier off, still flag
// - Terminal held active until reset-arbitration command or bit4 cleared
package tac_pkg;

    // ------------------------------------------------------------------
    // Serial port framing
    // ------------------------------------------------------------------
    localparam int ADDR_W        = 7;
    localparam int DATA_W        = 8;
    localparam logic [4:0] BIT_CNT_ADDR_LAST = 5'h07;
    localparam logic [4:0] BIT_CNT_DATA_LAST = 5'h0f;
    localparam logic [4:0] BIT_CNT_DATA_FIRST = 5'h08;

    // ------------------------------------------------------------------
    // Write and read addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] WR_OP_CTRL   = 7'h00;
    localparam logic [6:0] WR_POLARITY  = 7'h02;
    localparam logic [6:0] WR_ARB_RESET = 7'h0e;
    localparam logic [6:0] WR_TX_CFG    = 7'h33;
    localparam logic [6:0] RD_STATUS    = 7'h00;
    localparam logic [6:0] RD_EVENT     = 7'h05;

    // ------------------------------------------------------------------
    // Field positions, masks and reset values
    // ------------------------------------------------------------------
    localparam int OPC_AMPS     = 0;
    localparam int OPC_NARROW   = 1;
    localparam int OPC_VOICE_CH = 2;
    localparam int OPC_FOCC_B   = 3;
    localparam int OPC_AUTO_ARB = 4;
    localparam int OPC_SAT      = 5;
    localparam int OPC_ST       = 6;
    localparam int OPC_TIMER    = 7;
    localparam int TXC_VOICE    = 3;
    localparam int TXC_DATA     = 4;
    localparam int TXC_SUP      = 5;
    localparam int POL_RF_EN    = 2;
    localparam int ARB_BIT      = 2;

    localparam logic [7:0] OP_CTRL_MASK  = 8'hff;
    localparam logic [7:0] POLARITY_MASK = 8'h0f;
    localparam logic [7:0] TX_CFG_MASK   = 8'h3f;
    localparam logic [7:0] OP_CTRL_RST   = 8'h00;
    localparam logic [7:0] POLARITY_RST  = 8'h00;
    localparam logic [7:0] TX_CFG_RST    = 8'h00;

    // Trim, volume, tone, converter and correction registers
    localparam int NUM_AUX = 11;
    localparam logic [6:0] AUX_OFFSET [NUM_AUX] = '{
        7'h37, 7'h38, 7'h39, 7'h3a, 7'h3b, 7'h3c,
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44};
    localparam logic [7:0] AUX_MASK [NUM_AUX] = '{
        8'h07, 8'h1f, 8'h0f, 8'h0f, 8'h7f, 8'h0f,
        8'h07, 8'hff, 8'hff, 8'hff, 8'h1f};
    localparam logic [7:0] AUX_RESET [NUM_AUX] = '{
        8'h04, 8'h10, 8'h08, 8'h08, 8'h3f, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_ADDR,
        SPI_DATA
    } tac_spi_state_t;

    typedef struct packed {
        logic amps_mode;
        logic narrowband;
        logic voice_channel;
        logic focc_b_word;
        logic auto_arb;
        logic sat_dsat_enable;
        logic st_dst_enable;
        logic timer_cycle;
    } tac_mode_t;

    typedef struct packed {
        logic mute;
        logic wb_data_recc;
        logic wb_data_rvc;
        logic st_voice;
        logic sat_voice;
        logic st_sat_voice;
        logic nb_data_voice;
        logic dst_voice;
        logic dsat_voice;
        logic undefined;
    } tac_tx_sel_t;

    // ------------------------------------------------------------------
    // Transmit signal selection
    // ------------------------------------------------------------------
    function automatic tac_tx_sel_t tac_decode_tx(input logic [7:0] opc,
                                                  input logic [7:0] txc);
        tac_tx_sel_t s;
        logic [2:0]  en;
        logic [3:0]  cb;
        s  = '0;
        en = {txc[TXC_VOICE], txc[TXC_DATA], txc[TXC_SUP]};
        cb = {opc[OPC_NARROW], opc[OPC_VOICE_CH], opc[OPC_SAT], opc[OPC_ST]};
        s.mute          = (en == 3'b000);
        s.wb_data_recc  = (en == 3'b010) && !cb[2];
        s.wb_data_rvc   = (en == 3'b110) && (cb == 4'b0100);
        s.st_voice      = (en == 3'b110) && (cb == 4'b0101);
        s.sat_voice     = (en == 3'b101) && (cb == 4'b0110);
        s.st_sat_voice  = (en == 3'b111) && (cb == 4'b0111);
        s.nb_data_voice = (en == 3'b100) && (cb == 4'b1100);
        s.dst_voice     = (en == 3'b100) && (cb == 4'b1111);
        s.dsat_voice    = (en == 3'b100) && (cb == 4'b1110);
        // Combinations outside the table are flagged, nothing selected
        s.undefined     = !(s.mute || s.wb_data_recc || s.wb_data_rvc ||
                            s.st_voice || s.sat_voice || s.st_sat_voice ||
                            s.nb_data_voice || s.dst_voice ||
                            s.dsat_voice);
        return s;
    endfunction

    function automatic tac_mode_t tac_decode_mode(input logic [7:0] opc);
        tac_mode_t m;
        m.amps_mode       = opc[OPC_AMPS];
        m.narrowband      = opc[OPC_NARROW];
        m.voice_channel   = opc[OPC_VOICE_CH];
        m.focc_b_word     = opc[OPC_FOCC_B];
        m.auto_arb        = opc[OPC_AUTO_ARB];
        m.sat_dsat_enable = opc[OPC_SAT];
        m.st_dst_enable   = opc[OPC_ST];
        m.timer_cycle     = opc[OPC_TIMER];
        return m;
    endfunction

endpackage

// *** tac_spi_host.sv ***
// Host controller model: frames register accesses on the serial port.
// Assumes the system clock of the block; edges are paced in its cycles.
`timescale 1ns/10ps

module tac_spi_host (
    input  wire logic clock,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // ------------------------------------------------------------------
    // Frame: read flag, address, data; six clocks low, six high per bit
    // ------------------------------------------------------------------
    task automatic xfer(input logic [15:0] f, output logic [7:0] q);
        q = 8'h00;
        @(posedge clock);
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi <= f[i];
            repeat (5) @(posedge clock);
            @(negedge clock);
            if (i < 8)
                q[i] = spi_miso;
            @(posedge clock);
            spi_sclk <= 1'b1;
            repeat (6) @(posedge clock);
            spi_sclk <= 1'b0;
        end
        repeat (6) @(posedge clock);
        spi_cs_n <= 1'b1;
        // Released data line must not keep looking valid
        spi_mosi <= ~f[0];
        repeat (6) @(posedge clock);
    endtask

endmodule // tac_spi_host

// *** tac_tx_arb_ctrl.sv ***
// Transmit mode and arbitration control: serial register port, control
// word decode and the RF amplifier arbitration latch.
// Assumes serial pins asynchronous to clock, sclk well below clock / 4,
// and arb_fail_det a one-cycle pulse from logic on clock.
`timescale 1ns/10ps

module tac_tx_arb_ctrl
    import tac_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    input  wire logic        arb_fail_det,
    output tac_mode_t        mode,
    output tac_tx_sel_t      tx_sel,
    output logic             rf_amp_enable_pin,
    output logic             rf_transmit_output_en,
    output logic             arb_fail_status_bit,
    output logic             arb_fail_event_bit,
    output logic [7:0]       aux_regs [NUM_AUX]
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic       sclk_prev_reg;

    assign pin_raw = {spi_sclk, spi_cs_n, spi_mosi};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            // Reset to each pin's idle level: cs_n idles high, so a zero
            // here would open a phantom frame for two cycles after reset
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta_reg[g] <= (g == 1) ? 1'b1 : 1'b0;
                    pin_sync_reg[g] <= (g == 1) ? 1'b1 : 1'b0;
                end else begin
                    pin_meta_reg[g] <= pin_raw[g];
                    pin_sync_reg[g] <= pin_meta_reg[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= pin_sync_reg[2];
        end
    end

    wire sclk_s    = pin_sync_reg[2];
    wire cs_active = !pin_sync_reg[1];
    wire mosi_s    = pin_sync_reg[0];
    wire sclk_rise = cs_active && sclk_s && !sclk_prev_reg;
    wire sclk_fall = cs_active && !sclk_s && sclk_prev_reg;

    // ------------------------------------------------------------------
    // Serial frame: R/W bit, 7-bit address, 8 data bits, MSB first
    // ------------------------------------------------------------------
    tac_spi_state_t state_reg;
    tac_spi_state_t state_next;
    logic [4:0]     bit_cnt_reg;
    logic [7:0]     shift_reg;
    logic [6:0]     addr_reg;
    logic           rd_reg;
    logic [7:0]     rd_shift_reg;
    logic [7:0]     rd_data_reg;
    logic           miso_reg;

    wire [7:0] shift_in  = {shift_reg[6:0], mosi_s};
    wire       addr_done = sclk_rise && (bit_cnt_reg == BIT_CNT_ADDR_LAST);
    wire       data_done = sclk_rise && (bit_cnt_reg == BIT_CNT_DATA_LAST);
    wire       wr_commit = data_done && !rd_reg;
    wire [7:0] wr_data   = shift_in;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SPI_IDLE: begin
                if (cs_active) begin
                    state_next = SPI_ADDR;
                end
            end
            SPI_ADDR: begin
                if (!cs_active) begin
                    state_next = SPI_IDLE;
                end else if (addr_done) begin
                    state_next = SPI_DATA;
                end
            end
            SPI_DATA: begin
                // Extra clocks past the data byte are ignored until cs lifts
                if (!cs_active) begin
                    state_next = SPI_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= SPI_IDLE;
            bit_cnt_reg <= 5'h00;
            shift_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (!cs_active) begin
                bit_cnt_reg <= 5'h00;
            end else if (sclk_rise && bit_cnt_reg != BIT_CNT_DATA_LAST + 5'h01)
            begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                shift_reg   <= shift_in;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= 7'h00;
            rd_reg   <= 1'b0;
        end else if (addr_done) begin
            rd_reg   <= shift_in[7];
            addr_reg <= shift_in[6:0];
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] op_ctrl_reg;
    logic [7:0] polarity_reg;
    logic [7:0] tx_cfg_reg;

    wire wr_op_ctrl  = wr_commit && (addr_reg == WR_OP_CTRL);
    wire wr_polarity = wr_commit && (addr_reg == WR_POLARITY);
    wire wr_tx_cfg   = wr_commit && (addr_reg == WR_TX_CFG);
    wire arb_reset   = wr_commit && (addr_reg == WR_ARB_RESET);

    // Other addresses fall through untouched; masks drop upper bits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_ctrl_reg  <= OP_CTRL_RST;
            polarity_reg <= POLARITY_RST;
            tx_cfg_reg   <= TX_CFG_RST;
        end else begin
            if (wr_op_ctrl) begin
                op_ctrl_reg <= wr_data & OP_CTRL_MASK;
            end
            if (wr_polarity) begin
                polarity_reg <= wr_data & POLARITY_MASK;
            end
            if (wr_tx_cfg) begin
                tx_cfg_reg <= wr_data & TX_CFG_MASK;
            end
        end
    end

    generate
        for (g = 0; g < NUM_AUX; g++) begin : g_aux
            wire hit = wr_commit && (addr_reg == AUX_OFFSET[g]);
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    aux_regs[g] <= AUX_RESET[g];
                end else if (hit) begin
                    aux_regs[g] <= wr_data & AUX_MASK[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Mode and transmit selection outputs
    // ------------------------------------------------------------------
    wire tac_mode_t   mode_next   = tac_decode_mode(op_ctrl_reg);
    wire tac_tx_sel_t tx_sel_next = tac_decode_tx(op_ctrl_reg, tx_cfg_reg);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode   <= '0;
            tx_sel <= '0;
        end else begin
            mode   <= mode_next;
            tx_sel <= tx_sel_next;
        end
    end

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    logic arb_hold_reg;

    wire auto_arb   = op_ctrl_reg[OPC_AUTO_ARB];
    wire rf_act_lvl = polarity_reg[POL_RF_EN];
    wire rd_event   = sclk_fall && rd_reg &&
                      (bit_cnt_reg == BIT_CNT_DATA_FIRST) &&
                      (addr_reg == RD_EVENT);

    // Set wins over clear on every flag below
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arb_hold_reg        <= 1'b0;
            arb_fail_status_bit <= 1'b0;
            arb_fail_event_bit  <= 1'b0;
        end else begin
            if (arb_fail_det && auto_arb) begin
                arb_hold_reg <= 1'b1;
            end else if (arb_reset) begin
                arb_hold_reg <= 1'b0;
            end
            if (arb_fail_det) begin
                arb_fail_status_bit <= 1'b1;
            end else if (arb_reset) begin
                arb_fail_status_bit <= 1'b0;
            end
            if (arb_fail_det) begin
                arb_fail_event_bit <= 1'b1;
            end else if (rd_event) begin
                arb_fail_event_bit <= 1'b0;
            end
        end
    end

    // Software mode never latches, so the terminal stays inactive there
    wire rf_off = auto_arb && arb_hold_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rf_amp_enable_pin     <= 1'b1;
            rf_transmit_output_en <= 1'b1;
        end else begin
            rf_amp_enable_pin     <= rf_off ? rf_act_lvl
                                            : !rf_act_lvl;
            rf_transmit_output_en <= !rf_off;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [7:0] rd_sel =
        (shift_in[6:0] == RD_STATUS) ? (8'h00 | {5'h00, arb_fail_status_bit,
                                                 2'b00}) :
        (shift_in[6:0] == RD_EVENT)  ? (8'h00 | {5'h00, arb_fail_event_bit,
                                                 2'b00}) : 8'h00;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg  <= 8'h00;
            rd_shift_reg <= 8'h00;
            miso_reg     <= 1'b0;
        end else begin
            if (addr_done) begin
                rd_data_reg <= rd_sel;
            end
            if (sclk_fall && rd_reg && state_reg == SPI_DATA) begin
                if (bit_cnt_reg == BIT_CNT_DATA_FIRST) begin
                    miso_reg     <= rd_data_reg[7];
                    rd_shift_reg <= {rd_data_reg[6:0], 1'b0};
                end else begin
                    miso_reg     <= rd_shift_reg[7];
                    rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
                end
            end else if (!cs_active) begin
                miso_reg <= 1'b0;
            end
        end
    end

    assign spi_miso = miso_reg;

endmodule // tac_tx_arb_ctrl

// *** tac_tx_arb_ctrl_props.sv ***
// Checker for the transmit mode and arbitration control block.
// Sees only the top module ports; bound to every instance at the foot.
`timescale 1ns/10ps

module tac_tx_arb_ctrl_props
    import tac_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        spi_cs_n,
    input wire logic        arb_fail_det,
    input wire tac_mode_t   mode,
    input wire tac_tx_sel_t tx_sel,
    input wire logic        rf_amp_enable_pin,
    input wire logic        rf_transmit_output_en,
    input wire logic        arb_fail_status_bit,
    input wire logic        arb_fail_event_bit
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);

    arb_flags_a:
        assert property (arb_fail_det |=>
            arb_fail_status_bit && arb_fail_event_bit)
        else $error("arbitration flags not set");
    hw_cutoff_a:
        assert property (arb_fail_det && mode.auto_arb |->
            ##2 !rf_transmit_output_en)
        else $error("transmit output not cut off");
    pin_follow_a:
        assert property ($fell(rf_transmit_output_en) |->
            $changed(rf_amp_enable_pin))
        else $error("amplifier pin did not switch with cutoff");
    sw_keep_a:
        assert property (!mode.auto_arb [*3] |-> rf_transmit_output_en)
        else $error("cutoff in software arbitration");
    // Quiet serial port means no release command can be in flight
    arb_hold_a:
        assert property ((spi_cs_n && mode.auto_arb &&
            !rf_transmit_output_en) [*6] |=> !rf_transmit_output_en)
        else $error("cutoff released without command");
    mode_stable_a:
        assert property (spi_cs_n [*8] |=> $stable(mode))
        else $error("mode changed without a write");
    sel_onehot_a:
        assert property ($past(rst_n) |-> $onehot(tx_sel))
        else $error("transmit selection not one-hot");
    recc_sel_a:
        assert property (tx_sel.wb_data_recc |-> !mode.voice_channel)
        else $error("control channel data with voice channel set");
    dst_sel_a:
        assert property (tx_sel.dst_voice |-> mode.narrowband &&
            mode.sat_dsat_enable && mode.st_dst_enable)
        else $error("digital tone selected with wrong mode");
    dsat_sel_a:
        assert property (tx_sel.dsat_voice |-> mode.narrowband &&
            mode.sat_dsat_enable && !mode.st_dst_enable)
        else $error("digital audio tone selected with wrong mode");
    wb_sel_a:
        assert property (tx_sel.st_voice || tx_sel.sat_voice ||
            tx_sel.st_sat_voice || tx_sel.wb_data_rvc |->
            !mode.narrowband && mode.voice_channel)
        else $error("wideband voice selection with wrong mode");

    hw_cut_c: cover property (arb_fail_det && mode.auto_arb);
    dst_c:    cover property (tx_sel.dst_voice);
    undef_c:  cover property (tx_sel.undefined);

endmodule // tac_tx_arb_ctrl_props

bind tac_tx_arb_ctrl tac_tx_arb_ctrl_props i_props (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .spi_cs_n              (spi_cs_n),
    .arb_fail_det          (arb_fail_det),
    .mode                  (mode),
    .tx_sel                (tx_sel),
    .rf_amp_enable_pin     (rf_amp_enable_pin),
    .rf_transmit_output_en (rf_transmit_output_en),
    .arb_fail_status_bit   (arb_fail_status_bit),
    .arb_fail_event_bit    (arb_fail_event_bit)
);

// *** tb_top.sv ***
// Self-checking bench for the transmit mode and arbitration block.
// Drives registers through the serial host model; one 100 MHz clock.
`timescale 1ns/10ps

module tb_top;
    import tac_pkg::*;

    logic        clock;
    logic        rst_n;
    logic        arb_fail_det;
    wire         spi_sclk;
    wire         spi_cs_n;
    wire         spi_mosi;
    logic        spi_miso;
    tac_mode_t   mode;
    tac_tx_sel_t tx_sel;
    logic        rf_pin;
    logic        tx_en;
    logic        st_bit;
    logic        ev_bit;
    logic [7:0]  aux_regs [NUM_AUX];
    int          err_total;
    int          total_checks;
    logic [7:0]  q;

    localparam logic [2:0] EN_T [10] = '{3'b000, 3'b010, 3'b110,
        3'b110, 3'b101, 3'b111, 3'b100, 3'b100, 3'b100, 3'b100};
    localparam logic [3:0] CB_T [10] = '{4'b1111, 4'b1011, 4'b0100,
        4'b0101, 4'b0110, 4'b0111, 4'b1100, 4'b1111, 4'b1110, 4'b0000};

    tac_spi_host i_host (.clock(clock), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    tac_tx_arb_ctrl i_dut (.clock(clock), .rst_n(rst_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .arb_fail_det(arb_fail_det), .mode(mode),
        .tx_sel(tx_sel), .rf_amp_enable_pin(rf_pin),
        .rf_transmit_output_en(tx_en), .arb_fail_status_bit(st_bit),
        .arb_fail_event_bit(ev_bit), .aux_regs(aux_regs));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_host.xfer({1'b0, a, d}, r);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] r);
        i_host.xfer({1'b1, a, 8'h00}, r);
    endtask

    // Pulse lands on one edge; settle until the pins have answered
    task automatic fail_pulse;
        @(posedge clock);
        arb_fail_det <= 1'b1;
        @(posedge clock);
        arb_fail_det <= 1'b0;
        @(negedge clock);
        check(10'({st_bit, ev_bit}), 10'h3);
        @(posedge clock);
        @(negedge clock);
    endtask

    task automatic end_sim;
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] v;
        rst_n = 1'b0;
        arb_fail_det = 1'b0;
        err_total = 0;
        total_checks = 0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        for (int i = 0; i < NUM_AUX; i++)
            check(10'(aux_regs[i]), 10'(AUX_RESET[i]));
        check(10'({rf_pin, tx_en, mode}), 10'h300);
        check(10'(tx_sel), 10'h200);
        // Upper bits dropped, unused address leaves everything alone
        for (int i = 0; i < NUM_AUX; i++) begin
            wr(AUX_OFFSET[i], 8'hff);
            check(10'(aux_regs[i]), 10'(AUX_MASK[i]));
        end
        wr(7'h3d, 8'h55);
        for (int i = 0; i < NUM_AUX; i++)
            check(10'(aux_regs[i]), 10'(AUX_MASK[i]));
        for (int k = 0; k < 8; k++) begin
            v = 8'h01 << k;
            wr(WR_OP_CTRL, v);
            check(10'(mode), 10'({<<{v}}));
        end
        for (int i = 0; i < 10; i++) begin
            wr(WR_TX_CFG, {2'b00, EN_T[i][0], EN_T[i][1], EN_T[i][2],
                3'b000});
            wr(WR_OP_CTRL, {1'b0, CB_T[i][0], CB_T[i][1], 2'b00,
                CB_T[i][2], CB_T[i][3], 1'b0});
            check(10'(tx_sel), 10'h200 >> i);
        end
        wr(WR_OP_CTRL, 8'h00);
        fail_pulse();
        check(10'({rf_pin, tx_en}), 10'h3);
        rd(RD_STATUS, q);
        check(10'(q[ARB_BIT]), 10'h1);
        rd(RD_EVENT, q);
        check(10'(q[ARB_BIT]), 10'h1);
        rd(RD_EVENT, q);
        check(10'({q[ARB_BIT], ev_bit}), 10'h0);
        wr(WR_ARB_RESET, 8'h00);
        check(10'(st_bit), 10'h0);
        // Active-high polarity: inactive pin now sits low
        wr(WR_POLARITY, 8'h04);
        check(10'(rf_pin), 10'h0);
        wr(WR_OP_CTRL, 8'h10);
        fail_pulse();
        check(10'({rf_pin, tx_en}), 10'h2);
        repeat (40) @(posedge clock);
        wr(7'h37, 8'h01);
        check(10'({rf_pin, tx_en}), 10'h2);
        wr(WR_ARB_RESET, 8'h00);
        check(10'({rf_pin, tx_en, st_bit}), 10'h2);
        end_sim();
    end

endmodule // tb_top
